// ---- mrdr_regs.sv ----
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
// Behaviour
// (RL1) Profile bit 7: 0 FSK, 1 ASK
// (RL2) Select bit 1 uses second profile
// (RL3) Select bit 0 uses first profile
// (RL4) Profile bit 6 picks PA power range
// (RL5) ASK: high code sets data-high level
// (RL6) FSK: high code sets constant power
// (RL7) Power code monotonic, 1 min, 63 max
// (RL8) Duty bits 7:6 drive PA duty
// (RL9) Low-level code ignored under FSK
// (RL10) ASK ramp step lasts ramp-constant cycles
// (RL11) FSK transition spans divider*2*deviation steps
// (RL12) Divider divides by compare plus one
// (RL13) Host programs registers before transmitting
module mrdr_regs #(
    parameter int CODE_W = 6,
    parameter int POS_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit data pin, asynchronous
    input wire logic tx_data,
    // Output divider: 0 gives 1, 1 gives 2
    input wire logic output_divider_value,
    // FSK deviation code
    input wire logic [7:0] deviation_code,
    // Modulator and PA controls
    output logic pa_enable,
    output logic profile_modulation_type,
    output logic profile_power_range,
    output logic [CODE_W-1:0] pa_level,
    output logic [1:0] pa_drive_duty,
    output logic [POS_W-1:0] fsk_position,
    output logic bitrate_tick
);
    // Whole state of the block except the divider count
    // Bus, register and modulator state live in one struct, registered once
    typedef struct packed {
        // Bus channel state
        logic awready;
        logic wready;
        logic aw_held; // Write address captured
        logic [4:0] aw_idx;
        logic w_held; // Write data captured
        logic [7:0] w_data;
        logic w_stb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Configuration registers
        logic [7:0] prof0;
        logic [7:0] prof1;
        logic [7:0] duty_low;
        logic [7:0] amp_ramp;
        logic [7:0] frq_ramp;
        logic [7:0] div_cmp;
        logic [1:0] ctrl;
        // Data pin synchroniser
        logic sync1; // First synchroniser stage
        logic sync2;
        // Modulator sequencing state
        mrdr_pkg::mrdr_state_type mstate;
        // Copies latched at transmission start
        logic [7:0] act_prof; // Profile latched at start
        logic [7:0] act_duty;
        logic [7:0] act_aramp;
        logic [7:0] act_framp;
        // Ramp counters and outputs
        logic [POS_W-1:0] span;
        logic [7:0] acnt;
        logic [7:0] fcnt;
        logic [CODE_W-1:0] level;
        logic [POS_W-1:0] fpos;
        logic pa_on;
    } mrdr_regs_type;

    mrdr_regs_type s_r;
    mrdr_regs_type s_nxt;
    logic div_tick;

    // Bitrate / clock-output divider
    // Runs free from reset; a new compare value acts at once on the running count,
    // so the period in progress at a change may end early or run to the new compare
    // The tick is a one-cycle enable, never a derived clock
    mrdr_divider #(
        .WIDTH(8)
    ) u_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .compare(s_r.div_cmp),
        .tick(div_tick)
    );

    // Is an index a mapped register
    // Shared by the read and write paths so both agree on the error response
    function automatic logic is_mapped(input logic [4:0] idx);
        is_mapped = (idx >= mrdr_pkg::IDX_PROFILE0 && idx <= mrdr_pkg::IDX_DIV_CMP)
            || idx == mrdr_pkg::IDX_TX_CTRL || idx == mrdr_pkg::IDX_TX_STATUS;
    endfunction : is_mapped

    // Read mux; unmapped reads return zero
    // Status fields are sampled from live state when the address is
    // taken, so a read during a ramp returns a snapshot only
    function automatic logic [31:0] read_word(input mrdr_regs_type s, input logic [4:0] idx);
        read_word = '0;
        unique case (idx)
            mrdr_pkg::IDX_PROFILE0: read_word[7:0] = s.prof0;
            mrdr_pkg::IDX_PROFILE1: read_word[7:0] = s.prof1;
            mrdr_pkg::IDX_DUTY_LOW: read_word[7:0] = s.duty_low;
            mrdr_pkg::IDX_AMP_RAMP: read_word[7:0] = s.amp_ramp;
            mrdr_pkg::IDX_FRQ_RAMP: read_word[7:0] = s.frq_ramp;
            mrdr_pkg::IDX_DIV_CMP: read_word[7:0] = s.div_cmp;
            mrdr_pkg::IDX_TX_CTRL: read_word[1:0] = s.ctrl;
            mrdr_pkg::IDX_TX_STATUS: begin
                // Live state: running, level, FSK position
                read_word[0] = s.mstate == mrdr_pkg::MRDR_RUN;
                read_word[13:8] = s.level;
                read_word[25:16] = s.fpos;
            end
            default: read_word = '0;
        endcase
    endfunction : read_word

    // Step value one unit toward target each time the period elapses
    // The packed result carries the new value above the new period count
    // Counter restarts on every step, so each step lasts the full period
    // A zero period is taken as no ramp at all: value jumps to target
    // Counter is cleared while parked so a new target starts a full period
    function automatic logic [POS_W+7:0] ramp_step(input logic [POS_W-1:0] cur,
        input logic [POS_W-1:0] tgt, input logic [7:0] cnt, input logic [7:0] per);
        logic [POS_W-1:0] nv;
        logic [7:0] nc;
        nv = cur;
        nc = '0;
        if (cur == tgt) begin
            nc = '0;
        end else if (per == 8'h00) begin
            nv = tgt; // Zero constant: hard switch
        end else if (cnt + 8'h01 >= per) begin
            nv = (tgt > cur) ? cur + 1'b1 : cur - 1'b1;
        end else begin
            nc = cnt + 8'h01;
        end
        ramp_step = {nv, nc};
    endfunction : ramp_step

    // Next-state logic
    // Every field defaults to its current value; branches below override
    always_comb begin
        logic [POS_W+7:0] stp;
        logic [CODE_W-1:0] tgt_lvl;
        logic [POS_W-1:0] tgt_pos;
        logic wr_fire;
        logic [4:0] ridx;
        stp = '0;
        tgt_lvl = '0;
        tgt_pos = '0;
        wr_fire = 1'b0;
        ridx = '0;
        s_nxt = s_r;

        // Synchronise the data pin
        // The pin is asynchronous; two flops guard against metastability
        s_nxt.sync1 = tx_data;
        s_nxt.sync2 = s_r.sync1;

        // Write address and data are taken independently; each ready stays
        // low until the response handshake, so one write is in flight at most
        // Write address channel
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_idx = s_axi_awaddr[6:2];
            s_nxt.awready = 1'b0;
        end
        // Write data channel
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_stb = s_axi_wstrb[0];
            s_nxt.wready = 1'b0;
        end
        // Perform write once both halves are held
        // Unmapped index answers with an error and leaves all registers alone;
        // a cleared byte strobe still answers okay but writes nothing
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
            wr_fire = s_r.w_stb && is_mapped(s_r.aw_idx);
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(s_r.aw_idx) ? mrdr_pkg::RESP_OKAY : mrdr_pkg::RESP_SLVERR;
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
        end
        if (wr_fire) begin
            unique case (s_r.aw_idx)
                mrdr_pkg::IDX_PROFILE0: s_nxt.prof0 = s_r.w_data;
                mrdr_pkg::IDX_PROFILE1: s_nxt.prof1 = s_r.w_data;
                mrdr_pkg::IDX_DUTY_LOW: s_nxt.duty_low = s_r.w_data;
                mrdr_pkg::IDX_AMP_RAMP: s_nxt.amp_ramp = s_r.w_data;
                mrdr_pkg::IDX_FRQ_RAMP: s_nxt.frq_ramp = s_r.w_data;
                mrdr_pkg::IDX_DIV_CMP: s_nxt.div_cmp = s_r.w_data; // RL12
                mrdr_pkg::IDX_TX_CTRL: s_nxt.ctrl = s_r.w_data[1:0];
                default: s_nxt.ctrl = s_r.ctrl; // Status is read-only
            endcase
        end
        // Response handshake reopens both channels
        // No new take can overlap, since both readies are low until here
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        // Read channel
        // Read data is registered with the response, so it cannot change
        // while the master holds off rready
        if (s_axi_arvalid && s_r.arready) begin
            ridx = s_axi_araddr[6:2];
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = read_word(s_r, ridx);
            s_nxt.rresp = is_mapped(ridx) ? mrdr_pkg::RESP_OKAY : mrdr_pkg::RESP_SLVERR;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Modulator sequencing
        // Starting needs one idle cycle, so run must be cleared before a
        // restart picks up new settings
        unique case (s_r.mstate)
            // Idle: PA off, ramps parked at zero, waiting for the run bit
            mrdr_pkg::MRDR_IDLE: begin
                s_nxt.pa_on = 1'b0;
                s_nxt.level = '0;
                s_nxt.fpos = '0;
                s_nxt.acnt = '0;
                s_nxt.fcnt = '0;
                if (s_r.ctrl[mrdr_pkg::CTRL_RUN_BIT]) begin
                    // Settings latched at start of transmission
                    // Span is computed once here to keep the ramp path short
                    s_nxt.act_prof = s_r.ctrl[mrdr_pkg::CTRL_SEL_BIT]
                        ? s_r.prof1 // RL2
                        : s_r.prof0; // RL3
                    s_nxt.act_duty = s_r.duty_low; // RL13
                    s_nxt.act_aramp = s_r.amp_ramp;
                    s_nxt.act_framp = s_r.frq_ramp;
                    // Span = divider * 2 * deviation
                    s_nxt.span = POS_W'({1'b0, deviation_code, 1'b0})
                        << output_divider_value; // RL11
                    s_nxt.mstate = mrdr_pkg::MRDR_RUN;
                end
            end
            // Run: settings frozen at start; profile, duty and ramp register writes now only
            // prepare the next transmission
            // Data pin is read through the synchroniser only, never raw
            mrdr_pkg::MRDR_RUN: begin
                s_nxt.pa_on = 1'b1;
                if (s_r.act_prof[mrdr_pkg::PRF_TYPE_BIT] == mrdr_pkg::TYPE_ASK) begin // RL1
                    // High code for data high, low code for data low
                    // Level is ramped in both directions at the same step period
                    tgt_lvl = s_r.sync2 ? s_r.act_prof[mrdr_pkg::PRF_CODE_MSB:0] // RL5
                        : s_r.act_duty[mrdr_pkg::LOW_MSB:0];
                    stp = ramp_step(POS_W'(s_r.level), POS_W'(tgt_lvl), s_r.acnt,
                        s_r.act_aramp); // RL10
                    s_nxt.level = stp[CODE_W+7:8];
                    s_nxt.acnt = stp[7:0];
                    s_nxt.fpos = '0;
                end else begin
                    // Constant power, low code unused
                    // Frequency position ramps between zero and the latched span
                    s_nxt.level = s_r.act_prof[mrdr_pkg::PRF_CODE_MSB:0]; // RL6 RL9
                    tgt_pos = s_r.sync2 ? s_r.span : '0;
                    stp = ramp_step(s_r.fpos, tgt_pos, s_r.fcnt, s_r.act_framp); // RL11
                    s_nxt.fpos = stp[POS_W+7:8];
                    s_nxt.fcnt = stp[7:0];
                end
                if (!s_r.ctrl[mrdr_pkg::CTRL_RUN_BIT]) begin
                    s_nxt.mstate = mrdr_pkg::MRDR_IDLE;
                end
            end
        endcase
    end

    // State register
    // Reset is synchronous; the bus channels come out of reset ready so the
    // first request may be offered at the first edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            // Configuration registers return to their reset value
            s_r.prof0 <= mrdr_pkg::RST_REG8;
            s_r.prof1 <= mrdr_pkg::RST_REG8;
            s_r.duty_low <= mrdr_pkg::RST_REG8;
            s_r.amp_ramp <= mrdr_pkg::RST_REG8;
            s_r.frq_ramp <= mrdr_pkg::RST_REG8;
            s_r.div_cmp <= mrdr_pkg::RST_REG8;
            s_r.mstate <= mrdr_pkg::MRDR_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flip-flops
    // Profile fields come from the copy latched at start, not from the
    // registers, so the PA never sees a half-written setting mid-run
    // Bus handshake outputs
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    // Modulator outputs
    assign pa_enable = s_r.pa_on;
    assign profile_modulation_type = s_r.act_prof[mrdr_pkg::PRF_TYPE_BIT]; // RL1
    assign profile_power_range = s_r.act_prof[mrdr_pkg::PRF_RANGE_BIT]; // RL4
    assign pa_level = s_r.level; // RL7
    assign pa_drive_duty = s_r.act_duty[mrdr_pkg::DUTY_MSB:mrdr_pkg::DUTY_LSB]; // RL8
    assign fsk_position = s_r.fpos;
    assign bitrate_tick = div_tick;
endmodule : mrdr_regs

// ---- mrdr_pkg.sv ----
package mrdr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [4:0] IDX_PROFILE0 = 5'h0c;
    localparam logic [4:0] IDX_PROFILE1 = 5'h0d;
    localparam logic [4:0] IDX_DUTY_LOW = 5'h0e;
    localparam logic [4:0] IDX_AMP_RAMP = 5'h0f;
    localparam logic [4:0] IDX_FRQ_RAMP = 5'h10;
    localparam logic [4:0] IDX_DIV_CMP = 5'h11;
    localparam logic [4:0] IDX_TX_CTRL = 5'h18;
    localparam logic [4:0] IDX_TX_STATUS = 5'h19;
    // Reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    // Profile register fields
    localparam int PRF_TYPE_BIT = 7;
    localparam int PRF_RANGE_BIT = 6;
    localparam int PRF_CODE_MSB = 5;
    // Duty and low-level register fields
    localparam int DUTY_MSB = 7;
    localparam int DUTY_LSB = 6;
    localparam int LOW_MSB = 5;
    // Transmit control fields
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    // Modulation type encodings
    localparam logic TYPE_FSK = 1'b0;
    localparam logic TYPE_ASK = 1'b1;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Modulator states, one-hot
    typedef enum logic [1:0] {
        MRDR_IDLE = 2'b01,
        MRDR_RUN = 2'b10
    } mrdr_state_type;
endpackage : mrdr_pkg

// ---- mrdr_divider.sv ----
`timescale 1ns/100ps
// Divides aclk by compare value plus one into a one-cycle tick
module mrdr_divider #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] compare,
    output logic tick
);
    // Divider state
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic tick;
    } mrdr_div_type;

    mrdr_div_type s_r;
    mrdr_div_type s_nxt;

    // Count 0..compare, tick on wrap (RL12)
    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt >= compare) begin
            s_nxt.cnt = '0; // RL12
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            s_nxt.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule : mrdr_divider

// ---- mrdr_properties.sv ----
`timescale 1ns/100ps
// Bus timing and modulator checks at the register block ports
module mrdr_properties #(
    parameter int CODE_W = 6
) (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic pa_enable,
    input logic profile_modulation_type,
    input logic profile_power_range,
    input logic [1:0] pa_drive_duty,
    input logic [CODE_W-1:0] pa_level
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken on one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_resp_time: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after take");
    a_read_resp_time: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response not one cycle after take");
    a_write_refused: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while busy");
    a_read_refused: assert property (rd_taken |=> !s_axi_arready)
        else $error("read address ready while busy");
    a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    a_idle_level_zero: assert property (!pa_enable |-> pa_level == '0)
        else $error("PA level nonzero while idle");
    a_profile_held: assert property (pa_enable && $past(pa_enable) |->
        $stable(profile_modulation_type) && $stable(profile_power_range)
        && $stable(pa_drive_duty))
        else $error("profile fields changed during run");
    a_fsk_level_const: assert property (pa_enable && $past(pa_enable, 2)
        && profile_modulation_type == mrdr_pkg::TYPE_FSK |-> $stable(pa_level))
        else $error("FSK power level moved");
endmodule : mrdr_properties

bind mrdr_regs mrdr_properties #(.CODE_W(CODE_W)) i_props (.*);

// ---- mrdr_host.sv ----
`timescale 1ns/100ps
// Host model: AXI4-Lite master issuing one access at a time
module mrdr_host (
    input logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Quiet bus from time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
        s_axi_rready = 1'b0;
    end
    // Write one word to register index i
    task write(input logic [4:0] i, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {1'b0, i, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : write
    // Read one word from register index i
    task read(input logic [4:0] i, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {1'b0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : read
endmodule : mrdr_host

// ---- modulation_ramp_divider_regs_tb.sv ----
`timescale 1ns/100ps
// Register bank bench: register access, divider and modulator runs
module modulation_ramp_divider_regs_tb;
    logic aclk = 1'b0;
    logic aresetn, tx_data, output_divider_value, bitrate_tick, pa_enable;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, profile_modulation_type, profile_power_range;
    logic [7:0] s_axi_awaddr, s_axi_araddr, deviation_code;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, pa_drive_duty, rsp;
    logic [5:0] pa_level;
    logic [9:0] fsk_position;
    int fails = 0;
    int num_checks = 0;
    int n;
    // Divider compare values under test
    logic [7:0] cmp_list [4] = '{8'h00, 8'h04, 8'haa, 8'hff};
    mrdr_regs i_dut (.*);
    mrdr_host i_host (.*);
    // Clock, 4 ns period
    always #2 aclk = ~aclk;
    // Compare seen value against expectation
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task finish_test;
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Cycles between two divider ticks
    task gap(output int g);
        do @(posedge aclk); while (bitrate_tick !== 1'b1);
        g = 0;
        do begin
            @(posedge aclk);
            g++;
        end while (bitrate_tick !== 1'b1);
    endtask : gap
    // Short register write of the low byte
    task wr(input logic [4:0] i, input logic [7:0] d);
        i_host.write(i, {24'h0, d}, 4'h1, rsp);
    endtask : wr
    // Main sequence
    initial begin
        {tx_data, output_divider_value, aresetn} = '0;
        deviation_code = 8'h03;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, then pattern readback with upper bits dropped
        for (int i = 12; i < 18; i++) begin
            i_host.read(i[4:0], rd_v, rsp);
            chk(rd_v, 32'h0);
            i_host.write(i[4:0], {24'hffffff, 8'(i * 37)}, 4'h1, rsp);
            i_host.read(i[4:0], rd_v, rsp);
            chk(rd_v, {24'h0, 8'(i * 37)});
        end
        // Write without byte strobe leaves value
        i_host.write(mrdr_pkg::IDX_AMP_RAMP, 32'h77, 4'h0, rsp);
        chk(rsp, mrdr_pkg::RESP_OKAY);
        i_host.read(mrdr_pkg::IDX_AMP_RAMP, rd_v, rsp);
        chk(rd_v, 32'h0000_002b);
        // Unmapped place answers with slave error
        i_host.read(5'h1f, rd_v, rsp);
        chk(rsp, mrdr_pkg::RESP_SLVERR);
        chk(rd_v, 32'h0);
        wr(5'h1f, 8'h55);
        chk(rsp, mrdr_pkg::RESP_SLVERR);
        // Divider ratios at both ends and two values between
        foreach (cmp_list[k]) begin
            wr(mrdr_pkg::IDX_DIV_CMP, cmp_list[k]);
            gap(n);
            gap(n);
            chk(n, cmp_list[k] + 32'd1);
        end
        // Profiles: first FSK code 10, second ASK high range code 5
        wr(mrdr_pkg::IDX_PROFILE0, 8'h0a);
        wr(mrdr_pkg::IDX_PROFILE1, 8'hc5);
        wr(mrdr_pkg::IDX_DUTY_LOW, 8'h83);
        wr(mrdr_pkg::IDX_AMP_RAMP, 8'h02);
        wr(mrdr_pkg::IDX_FRQ_RAMP, 8'h01);
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h03);
        repeat (20) @(posedge aclk);
        chk({pa_enable, profile_modulation_type, profile_power_range}, 3'b111);
        chk(pa_drive_duty, 2'b10);
        chk(pa_level, 6'h03);
        wr(mrdr_pkg::IDX_PROFILE1, 8'h00);
        tx_data <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (pa_level !== 6'h05 && n < 50);
        // Two synchroniser cycles, two steps of two cycles, one to show
        chk(n, 32'd7);
        chk(profile_modulation_type, mrdr_pkg::TYPE_ASK);
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h00);
        // Idle follows the cleared run bit, PA off one cycle later
        repeat (3) @(posedge aclk);
        chk({pa_enable, pa_level}, 7'h0);
        // First profile, FSK with span 2 * 3 * 1
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h02);
        repeat (30) @(posedge aclk);
        chk({profile_modulation_type, profile_power_range}, 2'b00);
        chk(pa_level, 6'h0a);
        chk(fsk_position, 10'h006);
        // Status shows running, level and position
        i_host.read(mrdr_pkg::IDX_TX_STATUS, rd_v, rsp);
        chk(rd_v, 32'h0006_0a01);
        tx_data <= 1'b0;
        repeat (30) @(posedge aclk);
        chk({fsk_position, pa_level}, {10'h000, 6'h0a});
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h00);
        // Output divider 2 doubles the frequency span
        output_divider_value <= 1'b1;
        tx_data <= 1'b1;
        repeat (3) @(posedge aclk);
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h02);
        repeat (30) @(posedge aclk);
        chk(fsk_position, 10'h00c);
        tx_data <= 1'b0;
        wr(mrdr_pkg::IDX_TX_CTRL, 8'h00);
        output_divider_value <= 1'b0;
        // Every duty code reaches the PA
        for (int d = 0; d < 4; d++) begin
            wr(mrdr_pkg::IDX_DUTY_LOW, {d[1:0], 6'h03});
            wr(mrdr_pkg::IDX_TX_CTRL, 8'h02);
            repeat (4) @(posedge aclk);
            chk(pa_drive_duty, d[1:0]);
            wr(mrdr_pkg::IDX_TX_CTRL, 8'h00);
        end
        // Reset just after the run bit is cleared returns registers and outputs to reset values
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        i_host.read(mrdr_pkg::IDX_DUTY_LOW, rd_v, rsp);
        chk(rd_v, {24'h0, mrdr_pkg::RST_REG8});
        chk({pa_enable, pa_level}, 7'h0);
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        finish_test();
    end
endmodule : modulation_ramp_divider_regs_tb
